// file: aor_regs.svh
// register offsets, reset values and field positions of the output register bank
`ifndef AOR_REGS_SVH
`define AOR_REGS_SVH
`define AOR_EVENT_FLAGS_OFS    8'h00
`define AOR_DIE_HEAT_OFS       8'h01
`define AOR_MAG_LOW_OFS        8'h02
`define AOR_MAG_HIGH_OFS       8'h03
`define AOR_X_LOW_OFS          8'h04
`define AOR_X_HIGH_OFS         8'h05
`define AOR_Y_LOW_OFS          8'h06
`define AOR_Y_HIGH_OFS         8'h07
`define AOR_Z_LOW_OFS          8'h08
`define AOR_Z_HIGH_OFS         8'h09
`define AOR_SPARE_OFS          8'h0a
`define AOR_QUEUE_STATE_OFS    8'h0b
`define AOR_QX_LOW_OFS         8'h0c
`define AOR_QX_HIGH_OFS        8'h0d
`define AOR_QY_LOW_OFS         8'h0e
`define AOR_QY_HIGH_OFS        8'h0f
`define AOR_QZ_LOW_OFS         8'h10
`define AOR_QZ_HIGH_OFS        8'h11
`define AOR_EVENT_FLAGS_RST    8'h01
`define AOR_SPARE_RST          8'h00
`define AOR_QUEUE_STATE_RST    8'h00
`define AOR_QS_WMRK_BIT        7
`define AOR_QS_OVFL_BIT        6
`define AOR_WALK_STEPS         18
`endif

// file: aor_pkg.sv
// types shared by the output register bank
`default_nettype none
package aor_pkg;
	typedef logic [11:0] aor_sample_t;
	typedef struct packed {
		logic [7:0]  ptr;
		logic [7:0]  rd_data;
		logic        rd_valid;
		logic [7:0]  evt;
		logic [7:0]  qstate;
		logic [7:0]  spare;
		logic [7:0]  heat;
		aor_sample_t mag;
		aor_sample_t x;
		aor_sample_t y;
		aor_sample_t z;
		aor_sample_t qx;
		aor_sample_t qy;
		aor_sample_t qz;
	} aor_state_t;
endpackage : aor_pkg
`default_nettype wire

// file: aor_readout.sv
// output register bank with burst auto-increment, byte order and snapshot
`include "aor_regs.svh"
`default_nettype none
module aor_readout
	import aor_pkg::*;
(
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// serial port byte access
	input  wire logic        set_addr_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic        rd_i,
	output logic [7:0]       rd_data_o,
	output logic             rd_valid_o,
	output logic [7:0]       ptr_o,
	// configuration bits
	input  wire logic        byte_order_select_i,
	input  wire logic        heat_reading_sequence_enable_i,
	input  wire logic        magnitude_calc_enable_i,
	input  wire logic        x_axis_disable_i,
	input  wire logic        y_axis_disable_i,
	input  wire logic        z_axis_disable_i,
	input  wire logic        fast_read_enable_i,
	// sensor core data
	input  wire logic [7:0]  event_set_i,
	input  wire logic [7:0]  die_heat_i,
	input  wire logic [11:0] vector_magnitude_i,
	input  wire logic [11:0] x_sample_i,
	input  wire logic [11:0] y_sample_i,
	input  wire logic [11:0] z_sample_i,
	input  wire logic        queue_watermark_i,
	input  wire logic        queue_overflow_i,
	input  wire logic [5:0]  queue_count_i,
	input  wire logic [11:0] queued_x_i,
	input  wire logic [11:0] queued_y_i,
	input  wire logic [11:0] queued_z_i
);

	aor_state_t state_reg;
	aor_state_t state_next;

	// low register of a pair holds the lower byte, or the upper eight bits in big-endian
	function automatic logic [7:0] split_byte(input aor_sample_t v, input logic be,
			input logic hi);
		if (!hi)
			split_byte = be ? v[11:4] : v[7:0];
		else
			split_byte = be ? {v[3:0], 4'h0} : {4'h0, v[11:8]};
	endfunction : split_byte

	function automatic logic skipped(input logic [7:0] a, input logic temp_en,
			input logic mag_en, input logic xd, input logic yd, input logic zd,
			input logic fast);
		logic odd_pair;
		odd_pair = fast && a[0] && (a != `AOR_EVENT_FLAGS_OFS) && (a != `AOR_DIE_HEAT_OFS)
			&& (a != `AOR_QUEUE_STATE_OFS) && (a <= `AOR_QZ_HIGH_OFS);
		case (a)
			`AOR_DIE_HEAT_OFS: skipped = !temp_en;
			`AOR_MAG_LOW_OFS, `AOR_MAG_HIGH_OFS: skipped = !mag_en || odd_pair;
			`AOR_X_LOW_OFS, `AOR_X_HIGH_OFS, `AOR_QX_LOW_OFS, `AOR_QX_HIGH_OFS:
				skipped = xd || odd_pair;
			`AOR_Y_LOW_OFS, `AOR_Y_HIGH_OFS, `AOR_QY_LOW_OFS, `AOR_QY_HIGH_OFS:
				skipped = yd || odd_pair;
			`AOR_Z_LOW_OFS, `AOR_Z_HIGH_OFS, `AOR_QZ_LOW_OFS, `AOR_QZ_HIGH_OFS:
				skipped = zd || odd_pair;
			default: skipped = 1'b0;
		endcase
	endfunction : skipped

	// plain step: current samples loop back to 00h, queued samples loop within the queue
	function automatic logic [7:0] step(input logic [7:0] a);
		if (a == `AOR_Z_HIGH_OFS)
			step = `AOR_EVENT_FLAGS_OFS;
		else if (a == `AOR_QZ_HIGH_OFS)
			step = `AOR_QX_LOW_OFS;
		else
			step = a + 8'h01;
	endfunction : step

	function automatic logic [7:0] next_addr(input logic [7:0] a, input logic temp_en,
			input logic mag_en, input logic xd, input logic yd, input logic zd,
			input logic fast);
		logic [7:0] c;
		logic       found;
		c = a;
		found = 1'b0;
		// 00h is never skipped, so an all-disabled queue loop falls back there
		next_addr = `AOR_EVENT_FLAGS_OFS;
		// bounded walk over the address loop
		for (int i = 0; i < `AOR_WALK_STEPS; i++) begin
			c = step(c);
			if (!found && !skipped(c, temp_en, mag_en, xd, yd, zd, fast)) begin
				next_addr = c;
				found = 1'b1;
			end
		end
	endfunction : next_addr

	function automatic logic [7:0] reg_value(input aor_state_t s, input logic [7:0] a,
			input logic be);
		case (a)
			`AOR_EVENT_FLAGS_OFS: reg_value = s.evt;
			`AOR_DIE_HEAT_OFS:    reg_value = s.heat;
			`AOR_MAG_LOW_OFS:     reg_value = split_byte(s.mag, be, 1'b0);
			`AOR_MAG_HIGH_OFS:    reg_value = split_byte(s.mag, be, 1'b1);
			`AOR_X_LOW_OFS:       reg_value = split_byte(s.x, be, 1'b0);
			`AOR_X_HIGH_OFS:      reg_value = split_byte(s.x, be, 1'b1);
			`AOR_Y_LOW_OFS:       reg_value = split_byte(s.y, be, 1'b0);
			`AOR_Y_HIGH_OFS:      reg_value = split_byte(s.y, be, 1'b1);
			`AOR_Z_LOW_OFS:       reg_value = split_byte(s.z, be, 1'b0);
			`AOR_Z_HIGH_OFS:      reg_value = split_byte(s.z, be, 1'b1);
			`AOR_SPARE_OFS:       reg_value = s.spare;
			`AOR_QUEUE_STATE_OFS: reg_value = s.qstate;
			`AOR_QX_LOW_OFS:      reg_value = split_byte(s.qx, be, 1'b0);
			`AOR_QX_HIGH_OFS:     reg_value = split_byte(s.qx, be, 1'b1);
			`AOR_QY_LOW_OFS:      reg_value = split_byte(s.qy, be, 1'b0);
			`AOR_QY_HIGH_OFS:     reg_value = split_byte(s.qy, be, 1'b1);
			`AOR_QZ_LOW_OFS:      reg_value = split_byte(s.qz, be, 1'b0);
			`AOR_QZ_HIGH_OFS:     reg_value = split_byte(s.qz, be, 1'b1);
			default:              reg_value = 8'h00;
		endcase
	endfunction : reg_value

	logic rd_take;
	logic snap_take;
	assign rd_take = rd_i && !set_addr_i;
	// fresh snapshot at burst start and each time the loop passes 00h
	assign snap_take = set_addr_i || (rd_take && state_reg.ptr == `AOR_EVENT_FLAGS_OFS);

	always_comb begin
		state_next = state_reg;
		state_next.rd_valid = 1'b0;
		state_next.qstate = {queue_watermark_i, queue_overflow_i, queue_count_i};
		// reading 00h clears the flags, a same-cycle event still lands
		if (rd_take && state_reg.ptr == `AOR_EVENT_FLAGS_OFS)
			state_next.evt = 8'h00;
		state_next.evt = state_next.evt | event_set_i;
		if (snap_take) begin
			state_next.heat = die_heat_i;
			state_next.mag  = vector_magnitude_i;
			state_next.x    = x_sample_i;
			state_next.y    = y_sample_i;
			state_next.z    = z_sample_i;
			state_next.qx   = queued_x_i;
			state_next.qy   = queued_y_i;
			state_next.qz   = queued_z_i;
		end
		if (set_addr_i) begin
			state_next.ptr = addr_i;
		end else if (rd_i) begin
			state_next.rd_data  = reg_value(state_reg, state_reg.ptr, byte_order_select_i);
			state_next.rd_valid = 1'b1;
			state_next.ptr = next_addr(state_reg.ptr, heat_reading_sequence_enable_i,
				magnitude_calc_enable_i, x_axis_disable_i, y_axis_disable_i,
				z_axis_disable_i, fast_read_enable_i);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg        <= '0;
			state_reg.evt    <= `AOR_EVENT_FLAGS_RST;
			state_reg.qstate <= `AOR_QUEUE_STATE_RST;
			state_reg.spare  <= `AOR_SPARE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data_o  = state_reg.rd_data;
	assign rd_valid_o = state_reg.rd_valid;
	assign ptr_o      = state_reg.ptr;

	// checks
	logic rd_plain;
	assign rd_plain = rd_i && !set_addr_i;

	a_evt_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		event_set_i[0] |=> state_reg.evt[0] ##1 (state_reg.evt[0] || $past(rd_plain)))
		else $error("event flag lost");
	a_heat_skip: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h00 && !heat_reading_sequence_enable_i
		|=> ptr_o != 8'h01)
		else $error("temperature not skipped");
	a_mag_split: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h02 && byte_order_select_i
		|=> rd_valid_o && rd_data_o == state_reg.mag[11:4])
		else $error("magnitude big-endian byte wrong");
	a_mag_skip: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h01 && !magnitude_calc_enable_i
		|=> ptr_o != 8'h02 && ptr_o != 8'h03)
		else $error("magnitude not skipped");
	a_x_split: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h05 && !byte_order_select_i
		|=> rd_data_o == {4'h0, state_reg.x[11:8]})
		else $error("x high byte wrong");
	a_y_split: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h07 && byte_order_select_i
		|=> rd_data_o == {state_reg.y[3:0], 4'h0})
		else $error("y second byte wrong");
	a_z_split: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h08 && !byte_order_select_i
		|=> rd_data_o == state_reg.z[7:0])
		else $error("z low byte wrong");
	a_axis_skip: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && x_axis_disable_i && state_reg.ptr < 8'h12
		|=> ptr_o != 8'h04 && ptr_o != 8'h05 && ptr_o != 8'h0c && ptr_o != 8'h0d)
		else $error("disabled x axis visited");
	a_spare_read: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h0a |=> rd_data_o == 8'h00)
		else $error("spare register not zero");
	a_queue_state: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h0b
		|=> rd_data_o == {$past(queue_watermark_i, 2), $past(queue_overflow_i, 2),
			$past(queue_count_i, 2)})
		else $error("queue state wrong");
	a_qx_split: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h0c && byte_order_select_i
		|=> rd_data_o == state_reg.qx[11:4])
		else $error("queued x byte wrong");
	a_qz_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h11 && !x_axis_disable_i && !fast_read_enable_i
		|=> ptr_o == 8'h0c)
		else $error("queue loop broken");
	a_ptr_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h09 |=> ptr_o == 8'h00)
		else $error("pointer did not wrap");
	a_snap_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h04 ##1 rd_plain && state_reg.ptr == 8'h05
		|-> $stable(state_reg.x))
		else $error("sample split across snapshots");

	// a read that arrives with a pointer load is dropped, not half done
	a_read_refused: assert property (@(posedge mclk_i) disable iff (rst_i)
		set_addr_i && rd_i |=> !rd_valid_o)
		else $error("read taken with pointer load");
	a_valid_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain |=> rd_valid_o)
		else $error("read not answered");
	a_valid_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
		!rd_plain |=> !rd_valid_o)
		else $error("answer without read");
	// clearing read and a fresh event in one cycle: the event must survive
	a_flag_set_wins: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h00 |=> state_reg.evt == $past(event_set_i))
		else $error("event lost in clearing read");
	a_flag_read: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h00 |=> rd_data_o == $past(state_reg.evt))
		else $error("event flags read wrong");
	a_heat_read: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h01 |=> rd_data_o == state_reg.heat)
		else $error("temperature read wrong");
	a_y_skip: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && y_axis_disable_i && state_reg.ptr < 8'h12
		|=> ptr_o != 8'h06 && ptr_o != 8'h07 && ptr_o != 8'h0e && ptr_o != 8'h0f)
		else $error("disabled y axis visited");
	a_z_skip: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && z_axis_disable_i && state_reg.ptr < 8'h12
		|=> ptr_o != 8'h08 && ptr_o != 8'h09 && ptr_o != 8'h10 && ptr_o != 8'h11)
		else $error("disabled z axis visited");
	// fast read leaves out the second byte of every pair
	a_fast_skip: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && fast_read_enable_i && state_reg.ptr < 8'h12
		|=> !ptr_o[0] || ptr_o == 8'h01 || ptr_o == 8'h0b)
		else $error("fast read visited second byte");
	a_qy_split: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h0f && !byte_order_select_i
		|=> rd_data_o == {4'h0, state_reg.qy[11:8]})
		else $error("queued y byte wrong");
	a_qz_split: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h10 && byte_order_select_i
		|=> rd_data_o == state_reg.qz[11:4])
		else $error("queued z byte wrong");
	// loading the pointer freezes the live sample until the burst next reads 00h
	a_snap_take: assert property (@(posedge mclk_i) disable iff (rst_i)
		set_addr_i |=> state_reg.x == $past(x_sample_i))
		else $error("snapshot not taken at pointer load");
	a_mag_read: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h03 && !byte_order_select_i
		|=> rd_data_o == {4'h0, state_reg.mag[11:8]})
		else $error("magnitude high byte wrong");

	c_full_loop: cover property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h09 ##1 rd_plain && state_reg.ptr == 8'h00);
	c_fast_read: cover property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && fast_read_enable_i && state_reg.ptr == 8'h04 ##1 ptr_o == 8'h06);
	c_evt_clear: cover property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h00 && event_set_i != 8'h00);
	c_queue_loop: cover property (@(posedge mclk_i) disable iff (rst_i)
		rd_plain && state_reg.ptr == 8'h11 ##1 ptr_o == 8'h0c);
	c_refused_read: cover property (@(posedge mclk_i) disable iff (rst_i)
		set_addr_i && rd_i ##1 !rd_valid_o);

endmodule : aor_readout
`default_nettype wire

// file: aor_host.sv
// host model that loads the register pointer and reads bytes
`default_nettype none
module aor_host (
	// clock
	input  wire logic  mclk_i,
	// byte access requests
	output logic       set_addr_o,
	output logic [7:0] addr_o,
	output logic       rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		set_addr_o = 1'b0;
		addr_o     = 8'h00;
		rd_o       = 1'b0;
	end
	// address is junk unless loaded, so a design must not depend on it
	task automatic drive(input logic s, input logic [7:0] a, input logic r);
		@(negedge mclk_i);
		set_addr_o = s;
		addr_o     = s ? a : 8'($urandom);
		rd_o       = r;
	endtask : drive
endmodule : aor_host
`default_nettype wire

// file: aor_readout_tb.sv
// bench for the output register bank with a reference model of bursts
`default_nettype none
module aor_readout_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk_i, rst_i, set_w, rd_w, rvld, ev;
	logic [7:0]  addr_w, rdat, ptr, evs, evt, ed, ep, qs;
	// heat en, magnitude en, x/y/z disable, fast, big endian
	logic [6:0]  cfg;
	logic [11:0] live [8];
	logic [11:0] snap [8];
	int          n_mismatch, num_checks;
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	aor_host i_host (.mclk_i(mclk_i), .set_addr_o(set_w), .addr_o(addr_w), .rd_o(rd_w));
	aor_readout i_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .set_addr_i(set_w), .addr_i(addr_w), .rd_i(rd_w),
		.rd_data_o(rdat), .rd_valid_o(rvld), .ptr_o(ptr), .byte_order_select_i(cfg[0]),
		.heat_reading_sequence_enable_i(cfg[6]), .magnitude_calc_enable_i(cfg[5]),
		.x_axis_disable_i(cfg[4]), .y_axis_disable_i(cfg[3]), .z_axis_disable_i(cfg[2]),
		.fast_read_enable_i(cfg[1]), .event_set_i(evs), .die_heat_i(live[7][7:0]),
		.vector_magnitude_i(live[0]), .x_sample_i(live[1]), .y_sample_i(live[2]),
		.z_sample_i(live[3]), .queue_watermark_i(qs[7]), .queue_overflow_i(qs[6]),
		.queue_count_i(qs[5:0]), .queued_x_i(live[4]), .queued_y_i(live[5]),
		.queued_z_i(live[6])
	);
	function automatic logic skp(input logic [7:0] a);
		logic s;
		case (a)
			8'h01: s = !cfg[6];
			8'h02, 8'h03: s = !cfg[5];
			8'h04, 8'h05, 8'h0c, 8'h0d: s = cfg[4];
			8'h06, 8'h07, 8'h0e, 8'h0f: s = cfg[3];
			8'h08, 8'h09, 8'h10, 8'h11: s = cfg[2];
			default: s = 1'b0;
		endcase
		return s || (cfg[1] && a[0] && a > 8'h02 && a != 8'h0b && a < 8'h12);
	endfunction : skp
	function automatic logic [7:0] step(input logic [7:0] p);
		return (p == 8'h09) ? 8'h00 : (p == 8'h11) ? 8'h0c : p + 8'h01;
	endfunction : step
	function automatic logic [7:0] nxt(input logic [7:0] p);
		logic [7:0] q;
		q = p;
		for (int k = 0; k < 18; k++) begin
			q = step(q);
			if (!skp(q))
				return q;
		end
		return 8'h00;
	endfunction : nxt
	function automatic logic [7:0] exb(input logic [7:0] a);
		logic [11:0] v;
		case (a)
			8'h00: return evt;
			8'h01: return snap[7][7:0];
			8'h0a: return 8'h00;
			8'h0b: return qs;
			default: ;
		endcase
		v = snap[a < 8'h0a ? 3'((a - 8'h02) >> 1) : 3'(((a - 8'h0c) >> 1) + 8'h04)];
		if (cfg[0])
			return a[0] ? {v[3:0], 4'h0} : v[11:4];
		return a[0] ? {4'h0, v[11:8]} : v[7:0];
	endfunction : exb
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t valid got %b exp %b", $time, got, exp);
		end
	endtask : chk_flag
	// checks the previous edge, then sets up and predicts the coming one
	task automatic cyc(input logic s, input logic [7:0] a, input logic r);
		i_host.drive(s, a, r);
		chk_flag(rvld, ev);
		chk_byte(ptr, ep);
		if (ev)
			chk_byte(rdat, ed);
		for (int i = 0; i < 4; i++)
			live[i] = 12'($urandom);
		live[7] = 12'($urandom);
		ev = r && !s;
		// sparse events, some landing in the very cycle that clears the flags
		evs = ($urandom_range(0, 3) == 0) ? 8'($urandom) : 8'h00;
		if (s) begin
			cfg = 7'($urandom);
			qs = 8'($urandom);
			for (int i = 4; i < 7; i++)
				live[i] = 12'($urandom);
			snap = live;
			ep = a;
		end else if (ev) begin
			ed = exb(ep);
			// reading the flags clears them and takes a fresh snapshot
			if (ep == 8'h00) begin
				evt = 8'h00;
				snap = live;
			end
			ep = nxt(ep);
		end
		// a set in the clearing cycle still lands
		evt = evt | evs;
	endtask : cyc
	task automatic do_reset();
		@(negedge mclk_i);
		rst_i = 1'b1;
		evs = 8'h00;
		repeat (12) @(negedge mclk_i);
		rst_i = 1'b0;
		{evt, ep, ev} = {8'h01, 8'h00, 1'b0};
		chk_byte(rdat, 8'h00);
		chk_byte(ptr, 8'h00);
	endtask : do_reset
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		{rst_i, cfg, qs, evs, ev, ed} = '1;
		{cfg, qs, evs, ev, ed} = '0;
		foreach (live[i])
			live[i] = 12'h000;
		snap = live;
		void'($urandom(12489));
		do_reset();
		for (int b = 0; b < 80; b++) begin
			if (b == 40)
				do_reset();
			cyc(1'b1, 8'($urandom_range(0, 17)), 1'($urandom));
			repeat ($urandom_range(1, 12)) cyc(1'b0, 8'h00, 1'b1);
			cyc(1'b0, 8'h00, 1'b0);
		end
		summarize();
	end
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_mismatch++;
		summarize();
	end
endmodule : aor_readout_tb
`default_nettype wire
